//--- hdl/rpm_cfg.svh
// Purpose: constants of the receive-port clock and packet error monitor
// Assumes: 20 MHz ref_clk, four receive ports
// Notes:   offsets are byte addresses of the device register space
`ifndef RPM_CFG_SVH
`define RPM_CFG_SVH

`define RPM_NUM_PORTS       4
`define RPM_ADDR_PORT_SEL   8'h4C
`define RPM_ADDR_FD_CFG     8'h77
`define RPM_ADDR_MB0        8'h78
`define RPM_ADDR_MB1        8'h79
`define RPM_ADDR_STS        8'h7A
`define RPM_ADDR_CNT        8'h7B

`define RPM_F_PORT_SEL      1:0
`define RPM_F_HYST          7:6
`define RPM_F_STAB_SEL      5:4
`define RPM_F_LO_THR        3:0

`define RPM_B_LEN_ERR       3
`define RPM_B_PAYLOAD_CHECKSUM_ERROR_FLAG     2
`define RPM_B_MULTI_BIT_HEADER_ERROR_FLAG      1
`define RPM_B_SINGLE_BIT_HEADER_ERROR_FLAG      0

`define RPM_FD_CFG_RST      8'hC5
`define RPM_MB0_RST         8'h00
`define RPM_MB1_RST         8'h01
`define RPM_CNT_MAX         8'hFF

`define RPM_CLK_PERIOD_NS   50
`define RPM_STAB0_NS        40000
`define RPM_STAB1_NS        80000
`define RPM_STAB2_NS        320000
`define RPM_STAB3_NS        1280000
`define RPM_STAB_CYC(ns)    (((ns) + `RPM_CLK_PERIOD_NS - 1) / `RPM_CLK_PERIOD_NS)

`endif

//--- hdl/rpm_pkg.sv
// Purpose: types of the receive-port monitor
// Assumes: constants live in rpm_cfg.svh
// Notes:   state of each module is one packed struct
`default_nettype none

package rpm_pkg;

  typedef struct packed {
    logic [7:0] fd_cfg;
    logic [7:0] mb0;
    logic [7:0] mb1;
    logic [3:0] flags;
    logic [7:0] cnt;
  } rpm_port_regs_t;

  typedef struct packed {
    logic [1:0]                sel;
    rpm_port_regs_t [3:0]      port;
    logic [7:0]                rdata;
  } rpm_main_st_t;

  typedef struct packed {
    logic [7:0]  freq;
    logic [14:0] cnt;
    logic        stable;
    logic        no_clk;
  } rpm_fd_st_t;

endpackage

`default_nettype wire

//--- hdl/rpm_fd_if.sv
// Purpose: config and status between register bank and frequency detector
// Assumes: single ref_clk domain
// Notes:   ctl drives settings, det returns measurement state
`default_nettype none

interface rpm_fd_if;
  logic [1:0] hyst;
  logic [1:0] stab_sel;
  logic [3:0] lo_thr;
  logic [7:0] freq_mhz;
  logic       stable;
  logic       no_clk;

  modport ctl (output hyst, output stab_sel, output lo_thr,
               input freq_mhz, input stable, input no_clk);
  modport det (input hyst, input stab_sel, input lo_thr,
               output freq_mhz, output stable, output no_clk);
endinterface

`default_nettype wire

//--- hdl/rpm_freq_det.sv
// Purpose: per-port forwarded clock frequency detector
// Assumes: meas_valid pulses with a fresh MHz measurement, same clock
// Notes:   stored value moves only on excursions beyond hysteresis
`include "rpm_cfg.svh"
`default_nettype none

module rpm_freq_det #(
  parameter logic [14:0] STAB_CYC0 = 15'(`RPM_STAB_CYC(`RPM_STAB0_NS)),
  parameter logic [14:0] STAB_CYC1 = 15'(`RPM_STAB_CYC(`RPM_STAB1_NS)),
  parameter logic [14:0] STAB_CYC2 = 15'(`RPM_STAB_CYC(`RPM_STAB2_NS)),
  parameter logic [14:0] STAB_CYC3 = 15'(`RPM_STAB_CYC(`RPM_STAB3_NS))
) (
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  input  wire logic       meas_valid,
  input  wire logic [7:0] meas_mhz,
  rpm_fd_if.det           fd
);

  rpm_pkg::rpm_fd_st_t s_q;
  rpm_pkg::rpm_fd_st_t s_d;
  logic                excursion;
  logic [14:0]         lim;

  function automatic logic [14:0] stab_limit(input logic [1:0] sel);
    case (sel)
      2'h0:    stab_limit = STAB_CYC0;
      2'h1:    stab_limit = STAB_CYC1;
      2'h2:    stab_limit = STAB_CYC2;
      default: stab_limit = STAB_CYC3;
    endcase
  endfunction

  function automatic logic [7:0] abs_diff(input logic [7:0] a, input logic [7:0] b);
    abs_diff = (a > b) ? 8'(a - b) : 8'(b - a);
  endfunction

  assign lim = stab_limit(fd.stab_sel);
  assign excursion = meas_valid && (abs_diff(meas_mhz, s_q.freq) > {6'h00, fd.hyst});

  always_comb begin
    s_d = s_q;
    if (excursion) begin
      s_d.freq   = meas_mhz;
      s_d.cnt    = 15'h0000;
      s_d.stable = 1'b0;
    end else begin
      if (s_q.cnt < lim) begin
        s_d.cnt = 15'(s_q.cnt + 15'h0001);
      end
      s_d.stable = (s_q.cnt >= lim);
    end
    s_d.no_clk = (s_d.freq < {4'h0, fd.lo_thr});
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '{freq: 8'h00, cnt: 15'h0000, stable: 1'b0, no_clk: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  assign fd.freq_mhz = s_q.freq;
  assign fd.stable   = s_q.stable;
  assign fd.no_clk   = s_q.no_clk;

  property p_hyst_hold;
    @(posedge ref_clk) disable iff (!nrst)
      (meas_valid && abs_diff(meas_mhz, s_q.freq) <= {6'h00, fd.hyst})
        |=> (s_q.freq == $past(s_q.freq));
  endproperty
  a_hyst_hold: assert property (p_hyst_hold) else $error("freq moved inside hysteresis");

  property p_hyst_take;
    @(posedge ref_clk) disable iff (!nrst)
      excursion |=> (s_q.freq == $past(meas_mhz)) && !s_q.stable;
  endproperty
  a_hyst_take: assert property (p_hyst_take) else $error("excursion not captured");

  property p_stable_time;
    @(posedge ref_clk) disable iff (!nrst)
      $rose(s_q.stable) |-> ($past(s_q.cnt) >= $past(lim));
  endproperty
  a_stable_time: assert property (p_stable_time) else $error("stable before time");

  property p_low_thr;
    @(posedge ref_clk) disable iff (!nrst)
      ##1 (s_q.no_clk == (s_q.freq < {4'h0, $past(fd.lo_thr)}));
  endproperty
  a_low_thr: assert property (p_low_thr) else $error("no clock flag wrong");

  c_becomes_stable: cover property (@(posedge ref_clk) disable iff (!nrst) $rose(s_q.stable));

endmodule // rpm_freq_det

`default_nettype wire

//--- hdl/rpm_port_monitor.sv
// Purpose: per-receive-port clock detect, scratch and packet error registers
// Assumes: register strobes come from the device I2C target on ref_clk
// Notes:   read data is registered, valid the cycle after reg_rd
// Notes on behaviour
// - frequency updates only beyond hysteresis setting
// - stable after selectable in-range time
// - no link clock below low threshold
// - two scratch registers, resets 0x00, 0x01
// - length mismatch sets bit 3, read clears
// - payload checksum error sets bit 2
// - multi-bit header error sets bit 1
// - corrected single-bit header error sets bit 0
// - errored packet counter, cleared on read
// - port select routes per-port accesses
`include "rpm_cfg.svh"
`default_nettype none

module rpm_port_monitor #(
  parameter logic [14:0] STAB_CYC0 = 15'(`RPM_STAB_CYC(`RPM_STAB0_NS)),
  parameter logic [14:0] STAB_CYC1 = 15'(`RPM_STAB_CYC(`RPM_STAB1_NS)),
  parameter logic [14:0] STAB_CYC2 = 15'(`RPM_STAB_CYC(`RPM_STAB2_NS)),
  parameter logic [14:0] STAB_CYC3 = 15'(`RPM_STAB_CYC(`RPM_STAB3_NS))
) (
  input  wire logic            ref_clk,
  input  wire logic            nrst,
  input  wire logic [7:0]      reg_addr,
  input  wire logic            reg_wr,
  input  wire logic            reg_rd,
  input  wire logic [7:0]      reg_wdata,
  output logic      [7:0]      reg_rdata,
  input  wire logic [3:0]      ev_len_err,
  input  wire logic [3:0]      ev_payload_checksum_error_flag,
  input  wire logic [3:0]      ev_multi_bit_header_error_flag,
  input  wire logic [3:0]      ev_single_bit_header_error_flag,
  input  wire logic [3:0]      meas_valid,
  input  wire logic [3:0][7:0] meas_mhz,
  output logic      [3:0][7:0] freq_mhz,
  output logic      [3:0]      clock_stable,
  output logic      [3:0]      no_link_clock
);

  rpm_pkg::rpm_main_st_t s_q;
  rpm_pkg::rpm_main_st_t s_d;

  function automatic logic [3:0] port_events(input int p);
    port_events = '0;
    port_events[`RPM_B_LEN_ERR]   = ev_len_err[p];
    port_events[`RPM_B_PAYLOAD_CHECKSUM_ERROR_FLAG] = ev_payload_checksum_error_flag[p];
    port_events[`RPM_B_MULTI_BIT_HEADER_ERROR_FLAG]  = ev_multi_bit_header_error_flag[p];
    port_events[`RPM_B_SINGLE_BIT_HEADER_ERROR_FLAG]  = ev_single_bit_header_error_flag[p];
  endfunction

  function automatic logic [7:0] read_mux(input rpm_pkg::rpm_main_st_t s,
                                          input logic [7:0] addr);
    read_mux = 8'h00;
    case (addr)
      `RPM_ADDR_PORT_SEL: read_mux = {6'h00, s.sel};
      `RPM_ADDR_FD_CFG:   read_mux = s.port[s.sel].fd_cfg;
      `RPM_ADDR_MB0:      read_mux = s.port[s.sel].mb0;
      `RPM_ADDR_MB1:      read_mux = s.port[s.sel].mb1;
      `RPM_ADDR_STS:      read_mux = {4'h0, s.port[s.sel].flags};
      `RPM_ADDR_CNT:      read_mux = s.port[s.sel].cnt;
      default:            read_mux = 8'h00;
    endcase
  endfunction

  always_comb begin
    s_d = s_q;
    for (int p = 0; p < `RPM_NUM_PORTS; p++) begin
      if (reg_rd && (s_q.sel == 2'(p)) && (reg_addr == `RPM_ADDR_STS)) begin
        // clear on read, new events win
        s_d.port[p].flags = port_events(p);
      end else begin
        s_d.port[p].flags = s_q.port[p].flags | port_events(p);
      end
      if (reg_rd && (s_q.sel == 2'(p)) && (reg_addr == `RPM_ADDR_CNT)) begin
        s_d.port[p].cnt = {7'h00, |port_events(p)};
      end else if (|port_events(p) && (s_q.port[p].cnt != `RPM_CNT_MAX)) begin
        s_d.port[p].cnt = 8'(s_q.port[p].cnt + 8'h01);
      end
    end
    if (reg_wr) begin
      case (reg_addr)
        `RPM_ADDR_PORT_SEL: s_d.sel = reg_wdata[`RPM_F_PORT_SEL];
        `RPM_ADDR_FD_CFG:   s_d.port[s_q.sel].fd_cfg = reg_wdata;
        `RPM_ADDR_MB0:      s_d.port[s_q.sel].mb0 = reg_wdata;
        `RPM_ADDR_MB1:      s_d.port[s_q.sel].mb1 = reg_wdata;
        default:            s_d.sel = s_q.sel;
      endcase
    end
    if (reg_rd) begin
      s_d.rdata = read_mux(s_q, reg_addr);
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s_q.sel   <= 2'h0;
      s_q.rdata <= 8'h00;
      for (int p = 0; p < `RPM_NUM_PORTS; p++) begin
        s_q.port[p] <= '{fd_cfg: `RPM_FD_CFG_RST, mb0: `RPM_MB0_RST,
                         mb1: `RPM_MB1_RST, flags: 4'h0, cnt: 8'h00};
      end
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;

  for (genvar g = 0; g < `RPM_NUM_PORTS; g++) begin : g_port
    rpm_fd_if fd_if ();

    assign fd_if.hyst     = s_q.port[g].fd_cfg[`RPM_F_HYST];
    assign fd_if.stab_sel = s_q.port[g].fd_cfg[`RPM_F_STAB_SEL];
    assign fd_if.lo_thr   = s_q.port[g].fd_cfg[`RPM_F_LO_THR];

    rpm_freq_det #(
      .STAB_CYC0 (STAB_CYC0),
      .STAB_CYC1 (STAB_CYC1),
      .STAB_CYC2 (STAB_CYC2),
      .STAB_CYC3 (STAB_CYC3)
    ) u_det (
      .ref_clk    (ref_clk),
      .nrst       (nrst),
      .meas_valid (meas_valid[g]),
      .meas_mhz   (meas_mhz[g]),
      .fd         (fd_if.det)
    );

    assign freq_mhz[g]      = fd_if.freq_mhz;
    assign clock_stable[g]  = fd_if.stable;
    assign no_link_clock[g] = fd_if.no_clk;

    property p_len_set;
      @(posedge ref_clk) disable iff (!nrst)
        ev_len_err[g] |=> s_q.port[g].flags[`RPM_B_LEN_ERR];
    endproperty
    a_len_set: assert property (p_len_set) else $error("length flag lost");

    property p_cksum_set;
      @(posedge ref_clk) disable iff (!nrst)
        ev_payload_checksum_error_flag[g] |=> s_q.port[g].flags[`RPM_B_PAYLOAD_CHECKSUM_ERROR_FLAG];
    endproperty
    a_cksum_set: assert property (p_cksum_set) else $error("checksum flag lost");

    property p_ecc2_set;
      @(posedge ref_clk) disable iff (!nrst)
        ev_multi_bit_header_error_flag[g] |=> s_q.port[g].flags[`RPM_B_MULTI_BIT_HEADER_ERROR_FLAG];
    endproperty
    a_ecc2_set: assert property (p_ecc2_set) else $error("multi-bit flag lost");

    property p_ecc1_set;
      @(posedge ref_clk) disable iff (!nrst)
        ev_single_bit_header_error_flag[g] |=> s_q.port[g].flags[`RPM_B_SINGLE_BIT_HEADER_ERROR_FLAG];
    endproperty
    a_ecc1_set: assert property (p_ecc1_set) else $error("single-bit flag lost");

    property p_sts_rc;
      @(posedge ref_clk) disable iff (!nrst)
        (reg_rd && reg_addr == `RPM_ADDR_STS && s_q.sel == 2'(g) && !(|port_events(g)))
          |=> (s_q.port[g].flags == 4'h0)
              && (reg_rdata == {4'h0, $past(s_q.port[g].flags)});
    endproperty
    a_sts_rc: assert property (p_sts_rc) else $error("status not cleared on read");

    property p_cnt_rc;
      @(posedge ref_clk) disable iff (!nrst)
        (reg_rd && reg_addr == `RPM_ADDR_CNT && s_q.sel == 2'(g))
          |=> (reg_rdata == $past(s_q.port[g].cnt))
              && (s_q.port[g].cnt == {7'h00, $past(|port_events(g))});
    endproperty
    a_cnt_rc: assert property (p_cnt_rc) else $error("counter read wrong");

    property p_cnt_sat;
      @(posedge ref_clk) disable iff (!nrst)
        (s_q.port[g].cnt == `RPM_CNT_MAX && !(reg_rd && reg_addr == `RPM_ADDR_CNT))
          |=> (s_q.port[g].cnt == `RPM_CNT_MAX);
    endproperty
    a_cnt_sat: assert property (p_cnt_sat) else $error("counter wrapped");

    property p_cnt_inc;
      @(posedge ref_clk) disable iff (!nrst)
        ((|port_events(g)) && s_q.port[g].cnt != `RPM_CNT_MAX
         && !(reg_rd && reg_addr == `RPM_ADDR_CNT && s_q.sel == 2'(g)))
          |=> (s_q.port[g].cnt == 8'($past(s_q.port[g].cnt) + 8'h01));
    endproperty
    a_cnt_inc: assert property (p_cnt_inc) else $error("counter missed a packet");

    property p_route;
      @(posedge ref_clk) disable iff (!nrst)
        (reg_wr && reg_addr == `RPM_ADDR_MB0)
          |=> (s_q.port[g].mb0 == (($past(s_q.sel) == 2'(g)) ? $past(reg_wdata)
                                                               : $past(s_q.port[g].mb0)));
    endproperty
    a_route: assert property (p_route) else $error("write reached wrong port");

    c_cnt_full: cover property (@(posedge ref_clk) disable iff (!nrst)
                                s_q.port[g].cnt == `RPM_CNT_MAX);
    c_sts_read: cover property (@(posedge ref_clk) disable iff (!nrst)
                                reg_rd && reg_addr == `RPM_ADDR_STS && s_q.sel == 2'(g)
                                && s_q.port[g].flags != 4'h0);
    c_set_wins: cover property (@(posedge ref_clk) disable iff (!nrst)
                                reg_rd && reg_addr == `RPM_ADDR_STS && s_q.sel == 2'(g)
                                && (|port_events(g)));
  end

  property p_mb1_reset;
    @(posedge ref_clk) $rose(nrst) |-> (s_q.port[0].mb1 == `RPM_MB1_RST)
                                       && (s_q.port[0].mb0 == `RPM_MB0_RST);
  endproperty
  a_mb1_reset: assert property (p_mb1_reset) else $error("scratch reset value wrong");

  property p_sel_write;
    @(posedge ref_clk) disable iff (!nrst)
      (reg_wr && reg_addr == `RPM_ADDR_PORT_SEL)
        |=> (s_q.sel == $past(reg_wdata[`RPM_F_PORT_SEL]));
  endproperty
  a_sel_write: assert property (p_sel_write) else $error("port select not taken");

endmodule // rpm_port_monitor

`default_nettype wire

//--- bench/rpm_host_model.sv
// Purpose: host side register access model for the port monitor
// Assumes: single-cycle strobes, read data stands from the edge after the strobe
// Notes:   released bus shows the inverse of the last address and data
`default_nettype none

module rpm_host_model (
  input  wire logic       ref_clk,
  output var  logic [7:0] reg_addr,
  output var  logic       reg_wr,
  output var  logic       reg_rd,
  output var  logic [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_wdata = 8'h00;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1;
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_wr    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    #1;
    reg_addr = a;
    reg_rd   = 1'b1;
    @(posedge ref_clk);
    #1;
    d        = reg_rdata;
    reg_rd   = 1'b0;
    reg_addr = ~a;
  endtask

  task automatic sel(input logic [1:0] p);
    wr(8'h4C, {6'h00, p});
  endtask
endmodule // rpm_host_model

`default_nettype wire

//--- bench/test_rx_port_clock_and_csi_error_monitor.sv
// Purpose: self-checking bench of the receive-port monitor
// Assumes: stability counts shortened to 4, 8, 16 and 32 cycles
// Notes:   error kinds index ev as flag bit positions
`default_nettype none

module test_rx_port_clock_and_csi_error_monitor;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int LIM [4] = '{4, 8, 16, 32};

  logic            ref_clk;
  logic            nrst;
  logic [7:0]      reg_addr;
  logic [7:0]      reg_wdata;
  logic [7:0]      reg_rdata;
  logic            reg_wr;
  logic            reg_rd;
  logic [3:0][3:0] ev;
  logic [3:0]      meas_valid;
  logic [3:0][7:0] meas_mhz;
  logic [3:0][7:0] freq_mhz;
  logic [3:0]      clock_stable;
  logic [3:0]      no_link_clock;
  int              fail_count;
  int              checked;

  rpm_port_monitor #(
    .STAB_CYC0 (15'(LIM[0])),
    .STAB_CYC1 (15'(LIM[1])),
    .STAB_CYC2 (15'(LIM[2])),
    .STAB_CYC3 (15'(LIM[3]))
  ) i_rpm_port_monitor (
    .ref_clk       (ref_clk),
    .nrst          (nrst),
    .reg_addr      (reg_addr),
    .reg_wr        (reg_wr),
    .reg_rd        (reg_rd),
    .reg_wdata     (reg_wdata),
    .reg_rdata     (reg_rdata),
    .ev_len_err    (ev[3]),
    .ev_payload_checksum_error_flag  (ev[2]),
    .ev_multi_bit_header_error_flag   (ev[1]),
    .ev_single_bit_header_error_flag   (ev[0]),
    .meas_valid    (meas_valid),
    .meas_mhz      (meas_mhz),
    .freq_mhz      (freq_mhz),
    .clock_stable  (clock_stable),
    .no_link_clock (no_link_clock)
  );

  rpm_host_model i_rpm_host_model (
    .ref_clk   (ref_clk),
    .reg_addr  (reg_addr),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd),
    .reg_wdata (reg_wdata),
    .reg_rdata (reg_rdata)
  );

  always #25 ref_clk = ~ref_clk;

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string name);
    logic [7:0] v;
    i_rpm_host_model.rd(a, v);
    chk(name, v, exp);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic pulse(input logic [3:0] kinds, input int p, input int n);
    @(posedge ref_clk);
    #1;
    for (int k = 0; k < 4; k++) ev[k][p] = kinds[k];
    tick(n);
    ev = '0;
  endtask

  task automatic meas(input int p, input logic [7:0] m);
    @(posedge ref_clk);
    #1;
    meas_mhz[p]   = m;
    meas_valid[p] = 1'b1;
    tick(1);
    meas_valid[p] = 1'b0;
  endtask

  initial begin
    #500_000;
    fail_count++;
    tally_and_finish();
  end

  initial begin
    ref_clk    = 1'b0;
    nrst       = 1'b0;
    ev         = '0;
    meas_valid = '0;
    meas_mhz   = '0;
    fail_count = 0;
    checked    = 0;
    tick(3);
    nrst = 1'b1;
    chk("no_clk_rst", {4'h0, no_link_clock}, 8'h0F);
    chk("stable_rst", {4'h0, clock_stable}, 8'h00);
    rchk(8'h77, 8'hC5, "fd_cfg_rst");
    rchk(8'h78, 8'h00, "mb0_rst");
    rchk(8'h79, 8'h01, "mb1_rst");
    rchk(8'h7A, 8'h00, "flags_rst");
    rchk(8'h7B, 8'h00, "count_rst");
    for (int p = 0; p < 4; p++) begin
      i_rpm_host_model.sel(2'(p));
      i_rpm_host_model.wr(8'h78, 8'h10 + 8'(p));
      i_rpm_host_model.wr(8'h79, 8'hA0 + 8'(p));
    end
    for (int p = 0; p < 4; p++) begin
      i_rpm_host_model.sel(2'(p));
      rchk(8'h78, 8'h10 + 8'(p), "mb0_port");
      rchk(8'h79, 8'hA0 + 8'(p), "mb1_port");
    end
    // refused places, then port select readback
    i_rpm_host_model.wr(8'h7B, 8'h55);
    rchk(8'h7B, 8'h00, "count_ro");
    rchk(8'h50, 8'h00, "unmapped");
    rchk(8'h4C, 8'h03, "port_sel");
    i_rpm_host_model.sel(2'd2);
    for (int b = 0; b < 4; b++) begin
      pulse(4'(1 << b), 2, 1);
      rchk(8'h7A, 8'(8'h01 << b), "flag_set");
      rchk(8'h7A, 8'h00, "flag_clr");
    end
    rchk(8'h7B, 8'h04, "count_four");
    rchk(8'h7B, 8'h00, "count_clr");
    pulse(4'hF, 2, 1);
    rchk(8'h7A, 8'h0F, "flags_all");
    rchk(8'h7B, 8'h01, "count_one_pkt");
    fork
      pulse(4'h1, 2, 1);
      rchk(8'h7A, 8'h00, "flag_race_old");
    join
    rchk(8'h7A, 8'h01, "flag_set_wins");
    fork
      pulse(4'h2, 2, 1);
      rchk(8'h7B, 8'h01, "count_race_old");
    join
    rchk(8'h7B, 8'h01, "count_set_wins");
    i_rpm_host_model.sel(2'd0);
    rchk(8'h7A, 8'h00, "flags_other");
    i_rpm_host_model.sel(2'd3);
    pulse(4'h8, 3, 260);
    rchk(8'h7B, 8'hFF, "count_sat");
    rchk(8'h7A, 8'h08, "flag_len");
    i_rpm_host_model.sel(2'd1);
    meas(1, 8'h14);
    chk("freq_first", freq_mhz[1], 8'h14);
    tick(1);
    chk("no_clk_off", {7'h00, no_link_clock[1]}, 8'h00);
    meas(1, 8'h17);
    chk("freq_in_hyst", freq_mhz[1], 8'h14);
    meas(1, 8'h18);
    chk("freq_out_hyst", freq_mhz[1], 8'h18);
    i_rpm_host_model.wr(8'h77, 8'h05);
    meas(1, 8'h05);
    tick(1);
    chk("freq_at_thr", freq_mhz[1], 8'h05);
    chk("no_clk_at_thr", {7'h00, no_link_clock[1]}, 8'h00);
    meas(1, 8'h04);
    tick(1);
    chk("no_clk_below", {7'h00, no_link_clock[1]}, 8'h01);
    for (int s = 0; s < 4; s++) begin
      i_rpm_host_model.wr(8'h77, {2'b00, 2'(s), 4'h5});
      meas(1, (s % 2 == 1) ? 8'h3C : 8'h1E);
      tick(LIM[s] / 2);
      chk("unstable", {7'h00, clock_stable[1]}, 8'h00);
      tick(LIM[s] / 2 + 3);
      chk("stable", {7'h00, clock_stable[1]}, 8'h01);
    end
    chk("no_clk_ports", {4'h0, no_link_clock}, 8'h0D);
    // reset again in mid-run
    nrst = 1'b0;
    tick(1);
    nrst = 1'b1;
    chk("no_clk_rerst", {4'h0, no_link_clock}, 8'h0F);
    chk("freq_rerst", freq_mhz[1], 8'h00);
    chk("stable_rerst", {4'h0, clock_stable}, 8'h00);
    rchk(8'h4C, 8'h00, "sel_rerst");
    i_rpm_host_model.sel(2'd1);
    rchk(8'h79, 8'h01, "mb1_rerst");
    tally_and_finish();
  end
endmodule // test_rx_port_clock_and_csi_error_monitor

`default_nettype wire
